// file: sdc_consts.vh
// Named constants shared by the DDR command control block, its checks, the controller model and the testbench.
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH

// Command codes as {row strobe, column strobe, write enable}, all active low.
`define SDC_CMD_MRS       3'h0
`define SDC_CMD_REF       3'h1
`define SDC_CMD_PRE       3'h2
`define SDC_CMD_ACT       3'h3
`define SDC_CMD_WR        3'h4
`define SDC_CMD_RD        3'h5
`define SDC_CMD_BST       3'h6
`define SDC_CMD_NOP       3'h7

// Address pin field positions for the 16-bit-wide variant.
`define SDC_AP_BIT        10
`define SDC_ROW_W         13
`define SDC_COL_W         9
`define SDC_ADDR_W        13

// Operating mode word fields.
`define SDC_BL_MSB        2
`define SDC_BL_LSB        0
`define SDC_BT_BIT        3
`define SDC_CL_MSB        6
`define SDC_CL_LSB        4
`define SDC_DLL_BIT       8
`define SDC_BL_CODE_2     3'h1
`define SDC_BL_CODE_4     3'h2
`define SDC_BL_CODE_8     3'h3
`define SDC_MODE_RESET    13'h0000

// Bank address codes that select a mode word.
`define SDC_BA_BASE       2'h0
`define SDC_BA_EXTRA      2'h1

// Power states.
`define SDC_PS_RUN        2'h0
`define SDC_PS_PD_PRE     2'h1
`define SDC_PS_PD_ACT     2'h2
`define SDC_PS_SELF       2'h3

// Self refresh interval, in nanoseconds, and its length in clock cycles.
`define SDC_CLK_NS        10
`define SDC_TREFI_NS      7800
`define SDC_TREFI_CYC     (`SDC_TREFI_NS / `SDC_CLK_NS)

// Data widths.
`define SDC_DQ_W          16
`define SDC_DM_W          2
`define SDC_WORD_W        32
`define SDC_MASK_W        4

`endif

// file: sdc_fifo2.v
// Two-entry valid/ready buffer for captured write words.
`timescale 1ns/1ps
`default_nettype none

module sdc_fifo2 #(
  parameter WIDTH = 61
) (
  // Clock and reset.
  input  wire             clock,
  input  wire             rst,
  // Filling side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side.
  input  wire             out_ready,
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg             rd_ptr_q;
  reg             wr_ptr_q;
  reg [1:0]       count_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];

  // Pointers and fill count; a full buffer refuses new words.
  always @(posedge clock) begin
    if (rst) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

  // Storage needs no reset; the count guards it.
  always @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule // sdc_fifo2

`default_nettype wire

// file: sdc_ctrl.v
// DDR SDRAM device-side command, clock-enable and mode control.
`include "sdc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sdc_ctrl (
  // Clock and reset.
  input  wire                     clock,
  input  wire                     rst,
  // Memory command pins.
  input  wire                     ck,
  input  wire                     cke,
  input  wire                     cs_n,
  input  wire                     ras_n,
  input  wire                     cas_n,
  input  wire                     we_n,
  input  wire [1:0]               ba,
  input  wire [`SDC_ADDR_W-1:0]   addr,
  // Memory data pins.
  input  wire [`SDC_DM_W-1:0]     dm,
  input  wire [`SDC_DQ_W-1:0]     dq_in,
  output reg  [`SDC_DQ_W-1:0]     dq_out,
  output reg                      dq_oe_n,
  output reg                      dqs_out,
  output reg                      dqs_oe_n,
  // Core write port.
  output wire                     core_wr_valid,
  input  wire                     core_wr_ready,
  output wire [60:0]              core_wr_info,
  // Core read port.
  output reg                      core_rd_req,
  output reg  [23:0]              core_rd_addr,
  input  wire                     core_rd_valid,
  input  wire [`SDC_WORD_W-1:0]   core_rd_data,
  // Core refresh port.
  output reg                      refresh_pulse,
  output reg  [`SDC_ROW_W-1:0]    refresh_row,
  // Status.
  output reg  [3:0]               bank_open,
  output reg  [1:0]               power_state,
  output reg  [`SDC_ADDR_W-1:0]   operating_mode_word,
  output reg  [`SDC_ADDR_W-1:0]   extra_mode_word,
  output reg                      dll_reset_pulse,
  output reg                      write_stall
);

  localparam PIN_W = 1 + 1 + 1 + 3 + 2 + `SDC_ADDR_W + `SDC_DM_W + `SDC_DQ_W;
  localparam [12:0] TREFI_CYC = `SDC_TREFI_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Column of a beat within a wrapping burst block.
  // wrapping burst column.
  function [`SDC_COL_W-1:0] beat_col;
    input [`SDC_COL_W-1:0] start;
    input [2:0]            idx;
    input [2:0]            bl_code;
    input                  interleave;
    reg   [2:0]            mask;
    reg   [2:0]            low;
    begin
      mask = (bl_code == `SDC_BL_CODE_8) ? 3'h7 :
             (bl_code == `SDC_BL_CODE_4) ? 3'h3 : 3'h1;
      low  = interleave ? (start[2:0] ^ idx) : (start[2:0] + idx);
      beat_col = {start[`SDC_COL_W-1:3], (start[2:0] & ~mask) | (low & mask)};
    end
  endfunction

  // Number of double-width words in a burst.
  function [2:0] burst_words;
    input [2:0] bl_code;
    begin
      burst_words = (bl_code == `SDC_BL_CODE_8) ? 3'h4 :
                    (bl_code == `SDC_BL_CODE_4) ? 3'h2 : 3'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; the second stage is the only reader of the first.
  reg  [PIN_W-1:0] sync1_q;
  reg  [PIN_W-1:0] sync2_q;
  reg              ck_prev_q;

  always @(posedge clock) begin
    if (rst) begin
      sync1_q   <= {PIN_W{1'b1}};
      sync2_q   <= {PIN_W{1'b1}};
      ck_prev_q <= 1'b1;
    end else begin
      sync1_q   <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_in};
      sync2_q   <= sync1_q;
      ck_prev_q <= sync2_q[PIN_W-1];
    end
  end

  wire                   ck_s   = sync2_q[PIN_W-1];
  wire                   cke_s  = sync2_q[PIN_W-2];
  wire                   csn_s  = sync2_q[PIN_W-3];
  wire [2:0]             cmd_s  = sync2_q[PIN_W-4:PIN_W-6];
  wire [1:0]             ba_s   = sync2_q[PIN_W-7:PIN_W-8];
  wire [`SDC_ADDR_W-1:0] addr_s = sync2_q[`SDC_DQ_W+`SDC_DM_W+`SDC_ADDR_W-1:
                                          `SDC_DQ_W+`SDC_DM_W];
  wire [`SDC_DM_W-1:0]   dm_s   = sync2_q[`SDC_DQ_W+`SDC_DM_W-1:`SDC_DQ_W];
  wire [`SDC_DQ_W-1:0]   dq_s   = sync2_q[`SDC_DQ_W-1:0];

  // Rising edges register commands; both edges move data.
  wire ck_rise = ck_s & ~ck_prev_q;
  wire ck_fall = ~ck_s & ck_prev_q;
  wire is_nop  = csn_s | (cmd_s == `SDC_CMD_NOP);

  ////////////////////////////////////////////////////////////////////////////
  // Bank, burst and refresh state.
  reg                   cke_prev_q;
  reg [`SDC_ROW_W-1:0]  row_q [0:3];
  reg [1:0]             bst_bank_q;
  reg [`SDC_COL_W-1:0]  bst_col_q;
  reg [2:0]             bst_idx_q;
  reg [2:0]             words_left_q;
  reg                   bst_ap_q;
  reg                   rd_act_q;
  reg                   wr_act_q;
  reg [`SDC_WORD_W-1:0] rd_word_q;
  reg [`SDC_DQ_W-1:0]   wr_lo_q;
  reg [`SDC_DM_W-1:0]   wm_lo_q;
  reg [12:0]            sref_cnt_q;
  reg                   fifo_push_q;
  reg [60:0]            fifo_word_q;

  wire       all_idle  = (bank_open == 4'h0);
  wire [2:0] bl_code   = operating_mode_word[`SDC_BL_MSB:`SDC_BL_LSB];
  wire       bl_ilv    = operating_mode_word[`SDC_BT_BIT];
  wire       fifo_ready;

  // Command decode, clock-enable handling and burst sequencing.
  always @(posedge clock) begin
    if (rst) begin
      cke_prev_q          <= 1'b0;
      power_state         <= `SDC_PS_RUN;
      bank_open           <= 4'h0;
      operating_mode_word <= `SDC_MODE_RESET;
      extra_mode_word     <= `SDC_MODE_RESET;
      dll_reset_pulse     <= 1'b0;
      refresh_pulse       <= 1'b0;
      refresh_row         <= {`SDC_ROW_W{1'b0}};
      sref_cnt_q          <= 13'h0000;
      bst_bank_q          <= 2'h0;
      bst_col_q           <= {`SDC_COL_W{1'b0}};
      bst_idx_q           <= 3'h0;
      words_left_q        <= 3'h0;
      bst_ap_q            <= 1'b0;
      rd_act_q            <= 1'b0;
      wr_act_q            <= 1'b0;
      core_rd_req         <= 1'b0;
      core_rd_addr        <= 24'h000000;
    end else begin
      dll_reset_pulse <= 1'b0;
      refresh_pulse   <= 1'b0;
      core_rd_req     <= 1'b0;
      // Self refresh keeps rows alive from its own timer.
      if (power_state == `SDC_PS_SELF) begin
        if (sref_cnt_q == TREFI_CYC) begin
          sref_cnt_q    <= 13'h0000;
          refresh_pulse <= 1'b1;
          refresh_row   <= refresh_row + 13'h0001;
        end else begin
          sref_cnt_q <= sref_cnt_q + 13'h0001;
        end
      end else begin
        sref_cnt_q <= 13'h0000;
      end
      if (ck_rise) begin
        cke_prev_q <= cke_s;
        // Word boundary of an active burst: advance or finish.
        if (rd_act_q | wr_act_q) begin
          if (words_left_q == 3'h1) begin
            rd_act_q     <= 1'b0;
            wr_act_q     <= 1'b0;
            words_left_q <= 3'h0;
            if (bst_ap_q) begin
              bank_open[bst_bank_q] <= 1'b0;
            end
          end else begin
            words_left_q <= words_left_q - 3'h1;
            bst_idx_q    <= bst_idx_q + 3'h2;
            if (rd_act_q) begin
              core_rd_req  <= 1'b1;
              core_rd_addr <= {bst_bank_q, row_q[bst_bank_q],
                               beat_col(bst_col_q, bst_idx_q + 3'h2, bl_code, bl_ilv)};
            end
          end
        end
        case (power_state)
          `SDC_PS_RUN: begin
            if (cke_prev_q & cke_s & ~csn_s) begin
              case (cmd_s)
                `SDC_CMD_ACT: begin
                  bank_open[ba_s] <= 1'b1;
                  row_q[ba_s]     <= addr_s;
                end
                `SDC_CMD_RD, `SDC_CMD_WR: begin
                  bst_bank_q   <= ba_s;
                  bst_col_q    <= addr_s[`SDC_COL_W-1:0];
                  bst_idx_q    <= 3'h0;
                  words_left_q <= burst_words(bl_code);
                  bst_ap_q     <= addr_s[`SDC_AP_BIT];
                  rd_act_q     <= (cmd_s == `SDC_CMD_RD);
                  wr_act_q     <= (cmd_s == `SDC_CMD_WR);
                  if (cmd_s == `SDC_CMD_RD) begin
                    core_rd_req  <= 1'b1;
                    core_rd_addr <= {ba_s, row_q[ba_s],
                                     beat_col(addr_s[`SDC_COL_W-1:0], 3'h0,
                                              bl_code, bl_ilv)};
                  end
                end
                `SDC_CMD_BST: begin
                  if (rd_act_q & ~bst_ap_q) begin
                    rd_act_q     <= 1'b0;
                    words_left_q <= 3'h0;
                  end
                end
                `SDC_CMD_PRE: begin
                  if (addr_s[`SDC_AP_BIT]) begin
                    bank_open <= 4'h0;
                  end else begin
                    bank_open[ba_s] <= 1'b0;
                  end
                end
                // one refresh from the internal counter.
                `SDC_CMD_REF: begin
                  refresh_pulse <= 1'b1;
                  refresh_row   <= refresh_row + 13'h0001;
                end
                `SDC_CMD_MRS: begin
                  if (ba_s == `SDC_BA_BASE) begin
                    operating_mode_word <= addr_s;
                    dll_reset_pulse     <= addr_s[`SDC_DLL_BIT];
                  end else if (ba_s == `SDC_BA_EXTRA) begin
                    extra_mode_word <= addr_s;
                  end
                end
                default: begin
                end
              endcase
            end else if (cke_prev_q & ~cke_s) begin
              if (~csn_s & (cmd_s == `SDC_CMD_REF) & all_idle) begin
                power_state <= `SDC_PS_SELF;
              end else if (is_nop) begin
                power_state <= all_idle ? `SDC_PS_PD_PRE : `SDC_PS_PD_ACT;
              end
            end
          end
          default: begin
            // Exit from any low-power state needs enable high with a no-op.
            if (~cke_prev_q & cke_s & is_nop) begin
              power_state <= `SDC_PS_RUN;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one core word as two pin beats on reads.
  always @(posedge clock) begin
    if (rst) begin
      rd_word_q <= {`SDC_WORD_W{1'b0}};
      dq_out    <= {`SDC_DQ_W{1'b0}};
      dq_oe_n   <= 1'b1;
      dqs_out   <= 1'b0;
      dqs_oe_n  <= 1'b1;
    end else begin
      if (core_rd_valid) begin
        rd_word_q <= core_rd_data;
      end
      if (ck_fall & rd_act_q) begin
        dq_out   <= rd_word_q[`SDC_DQ_W-1:0];
        dq_oe_n  <= 1'b0;
        dqs_out  <= 1'b1;
        dqs_oe_n <= 1'b0;
      end else if (ck_rise & ~dq_oe_n) begin
        dq_out  <= rd_word_q[`SDC_WORD_W-1:`SDC_DQ_W];
        dqs_out <= 1'b0;
        // The last high beat keeps its drive until the rise after it ends.
        if (~rd_act_q) begin
          dq_oe_n  <= 1'b1;
          dqs_oe_n <= 1'b1;
        end
      end
    end
  end

  // two write beats pair into one word, low beat first.
  always @(posedge clock) begin
    if (rst) begin
      wr_lo_q     <= {`SDC_DQ_W{1'b0}};
      wm_lo_q     <= {`SDC_DM_W{1'b0}};
      fifo_push_q <= 1'b0;
      fifo_word_q <= 61'h0;
      write_stall <= 1'b0;
    end else begin
      fifo_push_q <= fifo_push_q & ~fifo_ready;
      write_stall <= ~fifo_ready;
      if (ck_fall & wr_act_q) begin
        wr_lo_q <= dq_s;
        wm_lo_q <= dm_s;
      end else if (ck_rise & wr_act_q) begin
        fifo_push_q <= 1'b1;
        fifo_word_q <= {1'b0, bst_bank_q, row_q[bst_bank_q],
                        beat_col(bst_col_q, bst_idx_q, bl_code, bl_ilv),
                        dm_s, wm_lo_q, dq_s, wr_lo_q};
      end
    end
  end

  // Write words wait here when the core stalls.
  sdc_fifo2 #(
    .WIDTH (61)
  ) u_wr_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (fifo_push_q),
    .in_ready  (fifo_ready),
    .in_data   (fifo_word_q),
    .out_ready (core_wr_ready),
    .out_valid (core_wr_valid),
    .out_data  (core_wr_info)
  );

endmodule // sdc_ctrl

`default_nettype wire

// file: sdc_ctrl_asserts.sv
// Concurrent checks on the ports of the DDR command control block.
`include "sdc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sdc_ctrl_asserts (
  // Clock and reset.
  input wire logic                   clock,
  input wire logic                   rst,
  // Data drive and core ports.
  input wire logic                   dq_oe_n,
  input wire logic                   dqs_oe_n,
  input wire logic                   core_wr_valid,
  input wire logic                   core_wr_ready,
  input wire logic [60:0]            core_wr_info,
  input wire logic                   core_rd_req,
  // Status.
  input wire logic                   refresh_pulse,
  input wire logic [3:0]             bank_open,
  input wire logic [1:0]             power_state,
  input wire logic [`SDC_ADDR_W-1:0] operating_mode_word,
  input wire logic                   dll_reset_pulse
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  property p_ref_idle;
    refresh_pulse |-> bank_open == 4'h0;
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("refresh with a bank open");
  property p_pd_pre;
    power_state == `SDC_PS_PD_PRE && $past(power_state) == `SDC_PS_RUN |-> bank_open == 4'h0;
  endproperty
  a_pd_pre: assert property (p_pd_pre) else $error("precharge power-down with open bank");
  property p_pd_act;
    power_state == `SDC_PS_PD_ACT && $past(power_state) == `SDC_PS_RUN |-> bank_open != 4'h0;
  endproperty
  a_pd_act: assert property (p_pd_act) else $error("active power-down with no open bank");
  property p_self_idle;
    power_state == `SDC_PS_SELF && $past(power_state) != `SDC_PS_SELF |-> bank_open == 4'h0;
  endproperty
  a_self_idle: assert property (p_self_idle) else $error("self refresh with open bank");
  property p_oe_pair;
    !dq_oe_n |-> !dqs_oe_n;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("data driven without strobe");
  property p_rd_beat;
    core_rd_req |-> ##[1:16] !dq_oe_n;
  endproperty
  a_rd_beat: assert property (p_rd_beat) else $error("read word never driven");
  property p_pd_hold;
    power_state != `SDC_PS_RUN |=> $stable(bank_open);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("bank state moved in power-down");
  property p_dll;
    dll_reset_pulse |-> ##[0:1] operating_mode_word[`SDC_DLL_BIT];
  endproperty
  a_dll: assert property (p_dll) else $error("delay-line reset without mode bit");
  property p_wr_hold;
    core_wr_valid && !core_wr_ready |=> core_wr_valid && $stable(core_wr_info);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled write word lost");
endmodule // sdc_ctrl_asserts

`default_nettype wire

// file: sdc_mc.sv
// Memory controller model driving clock, command, enable and write data pins.
`include "sdc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sdc_mc (
  // System clock.
  input  wire logic        clock,
  // Memory pins.
  output wire logic        ck,
  output var  logic        cke,
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [1:0]  ba,
  output var  logic [12:0] addr,
  output var  logic [1:0]  dm,
  output var  logic [15:0] dq_in
);
  logic [2:0] ph = 3'h0;

  // The memory clock runs free at one eighth of the system rate, 80 ns.
  always @(posedge clock) begin
    ph <= ph + 3'h1;
  end
  assign ck = ph[2];

  // Deselect with enable low until the first command.
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h0F;
    {ba, addr, dm, dq_in} = 33'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waits for the edge at which the memory clock falls.
  task cyc;
    do @(posedge clock); while (ph != 3'h7);
  endtask

  // held across rise
  // Pins change at a fall only, so they are steady around the sampled rise.
  task cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    cyc();
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    cke <= k;
    cyc();
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= 3'h7;
    ba <= ~b;
    addr <= ~a;
  endtask

  // mask with beat
  // Low beat while the clock is low, high beat while it is high, then flipped lines.
  task wr(input logic [1:0] b, input logic [12:0] a, input logic [15:0] lo,
          input logic [15:0] hi, input logic [1:0] mlo, input logic [1:0] mhi);
    cmd(`SDC_CMD_WR, b, a, 1'b1);
    dq_in <= lo;
    dm <= mlo;
    repeat (4) @(posedge clock);
    dq_in <= hi;
    dm <= mhi;
    cyc();
    dq_in <= ~hi;
    dm <= ~mhi;
  endtask
endmodule // sdc_mc

`default_nettype wire

// file: sdc_ctrl_tb_top.sv
// Testbench top for the DDR command control block.
`include "sdc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sdc_ctrl_tb_top;
  // Stable period and self-refresh exit wait, in memory clocks, shortened for the run.
  localparam int          STABLE_CK = 20;
  localparam int          EXIT_CK   = 25;
  localparam logic [12:0] AP        = 13'h0400;
  localparam logic [31:0] RDW       = 32'hC3A5_5A3C;
  logic        clock         = 1'b0;
  logic        rst           = 1'b1;
  logic        core_wr_ready = 1'b0;
  logic        core_rd_valid = 1'b0;
  logic [31:0] core_rd_data  = 32'h0;
  logic [23:0] rd_addr_q     = 24'h0;
  int          error_cnt     = 0;
  int          comparisons   = 0;
  int          ref_n         = 0;
  int          dll_n         = 0;
  int          cyc_n         = 0;
  wire         ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_out, dqs_oe_n;
  wire         core_wr_valid, core_rd_req, refresh_pulse, dll_reset_pulse, write_stall;
  wire [1:0]   ba, dm, power_state;
  wire [12:0]  addr, operating_mode_word, extra_mode_word, refresh_row;
  wire [15:0]  dq_in, dq_out;
  wire [60:0]  core_wr_info;
  wire [23:0]  core_rd_addr;
  wire [3:0]   bank_open;

  sdc_mc mc_u (.*);
  sdc_ctrl dut_u (.*);

  // 100 MHz system clock.
  always #5 clock = ~clock;

  // Core answers a read on the next clock; pulses are counted; a hang is cut short.
  always @(posedge clock) begin
    core_rd_valid <= core_rd_req;
    core_rd_data <= core_rd_req ? RDW : ~RDW;
    if (core_rd_req) begin
      rd_addr_q <= core_rd_addr;
    end
    ref_n <= ref_n + refresh_pulse;
    dll_n <= dll_n + dll_reset_pulse;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 8000) begin
      error_cnt++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Lets status updates after a command settle before looking.
  task nap;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task wph(input logic [2:0] k);
    do @(posedge clock); while (mc_u.ph != k);
    #1;
  endtask

  // Waits for a buffered word, compares it, then takes it with one ready clock.
  task drain(input logic [60:0] exp);
    for (int i = 0; i < 20 && core_wr_valid !== 1'b1; i++) nap();
    chk(core_wr_info, exp, "write word");
    @(posedge clock);
    core_wr_ready <= 1'b1;
    @(posedge clock);
    core_wr_ready <= 1'b0;
    #1;
  endtask

  task print_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: reset, initialization, banks, writes, a read, power states.
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    nap();
    chk({dq_oe_n, power_state}, {1'h1, `SDC_PS_RUN}, "idle");
    mc_u.cmd(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    repeat (STABLE_CK) mc_u.cyc();
    mc_u.cmd(`SDC_CMD_PRE, 2'h0, AP, 1'b1);
    mc_u.cmd(`SDC_CMD_MRS, `SDC_BA_EXTRA, 13'h0002, 1'b1);
    mc_u.cmd(`SDC_CMD_MRS, `SDC_BA_BASE, 13'h0121, 1'b1);
    repeat (200) mc_u.cyc();
    mc_u.cmd(`SDC_CMD_PRE, 2'h0, AP, 1'b1);
    repeat (2) mc_u.cmd(`SDC_CMD_REF, 2'h3, 13'h1FFF, 1'b1);
    mc_u.cmd(`SDC_CMD_MRS, `SDC_BA_BASE, 13'h0021, 1'b1);
    nap();
    chk(extra_mode_word, 13'h0002, "extra mode");
    chk(operating_mode_word, 13'h0021, "base mode");
    chk(dll_n, 1, "delay-line resets");
    chk(ref_n, 2, "refreshes");
    chk(refresh_row, 13'h0002, "refresh row");
    mc_u.cmd(`SDC_CMD_ACT, 2'h1, 13'h1ABC, 1'b1);
    mc_u.cmd(`SDC_CMD_ACT, 2'h2, 13'h0123, 1'b1);
    mc_u.cmd(`SDC_CMD_PRE, 2'h1, 13'h0000, 1'b1);
    nap();
    chk(bank_open, 4'h4, "one bank closed");
    mc_u.cmd(`SDC_CMD_PRE, 2'h1, AP, 1'b1);
    nap();
    chk(bank_open, 4'h0, "all closed");
    // Two words with the core stalled fill the buffer before it drains.
    mc_u.cmd(`SDC_CMD_ACT, 2'h0, 13'h0ABC, 1'b1);
    mc_u.wr(2'h0, 13'h0007, 16'h1234, 16'hABCD, 2'h0, 2'h2);
    mc_u.wr(2'h0, AP | 13'h01F0, 16'h5678, 16'h9EF0, 2'h1, 2'h3);
    nap();
    chk(write_stall, 1'h1, "buffer full");
    drain({3'h0, 13'h0ABC, 9'h007, 2'h2, 2'h0, 16'hABCD, 16'h1234});
    drain({3'h0, 13'h0ABC, 9'h1F0, 2'h3, 2'h1, 16'h9EF0, 16'h5678});
    nap();
    chk({core_wr_valid, bank_open}, {1'h0, 4'h0}, "drained and closed");
    mc_u.cmd(`SDC_CMD_ACT, 2'h3, 13'h1555, 1'b1);
    mc_u.cmd(`SDC_CMD_RD, 2'h3, 13'h0002, 1'b1);
    wph(3'h4);
    chk({dq_oe_n, dqs_out, dq_out}, {2'h1, RDW[15:0]}, "low beat");
    wph(3'h0);
    chk({dq_oe_n, dqs_out, dq_out}, {2'h0, RDW[31:16]}, "high beat");
    wph(3'h0);
    chk(dq_oe_n, 1'h1, "released");
    chk(rd_addr_q, {2'h3, 13'h1555, 9'h002}, "read place");
    chk(bank_open, 4'h8, "row kept open");
    mc_u.cmd(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'b0);
    nap();
    chk(power_state, `SDC_PS_PD_ACT, "active power-down");
    mc_u.cmd(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    mc_u.cmd(`SDC_CMD_PRE, 2'h0, AP, 1'b1);
    mc_u.cmd(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'b0);
    mc_u.cmd(`SDC_CMD_ACT, 2'h0, 13'h0001, 1'b0);
    nap();
    chk({power_state, bank_open}, {`SDC_PS_PD_PRE, 4'h0}, "power-down kept");
    mc_u.cmd(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    mc_u.cmd(`SDC_CMD_REF, 2'h0, 13'h0000, 1'b0);
    nap();
    chk(power_state, `SDC_PS_SELF, "self refresh");
    mc_u.cmd(`SDC_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    repeat (EXIT_CK) mc_u.cyc();
    nap();
    chk(power_state, `SDC_PS_RUN, "running");
    print_verdict();
  end
endmodule // sdc_ctrl_tb_top

// Checker attached to every instance of the block.
bind sdc_ctrl sdc_ctrl_asserts chk_u (.*);

`default_nettype wire
